/* File: bench/spi_far_end.sv */
// far-side model: a slave for master runs, a master for slave runs
// assumes clk is the device timer clock and the same pins face the device
`timescale 1ns/100ps
`default_nettype none
module spi_far_end (
	input  wire logic clk,
	input  wire logic serialOutPin,
	input  wire logic serialOutEnN,
	input  wire logic serialClockOut,
	output logic      serialInPin,
	output logic      serialClockIn,
	output logic      selectInN
);
	logic [7:0] slvTx;
	logic [7:0] slvRx;
	logic [2:0] cnt;
	logic       ph;
	logic       clkPrev;
	logic       outPrev;
	// a released line has no pull, so it shows the inverse of the last bit
	wire        outSeen = serialOutEnN ? ~serialOutPin : serialOutPin;
	assign serialInPin = slvTx[7];
	initial begin
		slvTx = 8'h00;
		slvRx = 8'h00;
		cnt = 3'h0;
		ph = 1'b0;
		clkPrev = 1'b0;
		outPrev = 1'b1;
		serialClockIn = 1'b0;
		selectInN = 1'b1;
	end
	// slave side of a master run; data captured as it stood at the clock edge
	always @(posedge clk) begin
		if (serialClockOut != clkPrev) begin
			if (serialClockOut ^ ph) begin
				slvRx = {slvRx[6:0], outPrev};
				cnt = cnt + 3'h1;
			end else if (cnt != 3'h0) begin
				slvTx = {slvTx[6:0], ~slvTx[0]};
			end
		end
		clkPrev = serialClockOut;
		outPrev = outSeen;
	end
	// master side: select frames the byte, clock held low between frames
	task automatic xfer(input logic [7:0] b, output logic [7:0] got);
		int i;
		for (i = 7; i >= 0; i--) begin
			slvTx[7] = b[i];
			repeat (4) @(posedge clk);
			#1 serialClockIn = 1'b1;
			got[i] = outSeen;
			repeat (4) @(posedge clk);
			#1 serialClockIn = 1'b0;
		end
		slvTx[7] = ~slvTx[7];
	endtask : xfer
	task automatic frame(input logic on);
		@(posedge clk);
		#1 selectInN = !on;
		repeat (4) @(posedge clk);
	endtask : frame
endmodule : spi_far_end
`default_nettype wire

/* File: bench/spi_with_address_compare_tb_top.sv */
// self-checking bench for the serial interface with address compare
// assumes the far-side model in spi_far_end.sv and a 50 MHz clk
`timescale 1ns/100ps
`default_nettype none
`include "spi_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module spi_with_address_compare_tb_top;
	import spi_pkg::*;
	logic       clk;
	logic       resetn;
	logic [7:0] regAddr;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic       txValid;
	logic [7:0] txData;
	logic       txReady;
	logic       firstTimerOutput;
	logic       serialInPin;
	logic       serialOutPin;
	logic       serialOutEnN;
	logic       serialClockIn;
	logic       serialClockOut;
	logic       serialClockEnN;
	logic       selectInN;
	logic       spiInterruptLine;
	logic       stopWakeSignal;
	int         fail_count = 0;
	int         n_checks = 0;
	int         irqs = 0;
	int         wakes = 0;
	int         tmrDiv = 0;
	logic [7:0] rv;
	logic [7:0] got;
	always #10 clk = ~clk;
	// free-running timer output, one level change every four clocks
	always @(posedge clk) begin
		tmrDiv++;
		#1 firstTimerOutput = tmrDiv[2];
	end
	always @(posedge clk) begin
		irqs += spiInterruptLine;
		wakes += stopWakeSignal;
	end
	spi_with_address_compare u_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.txValid(txValid), .txData(txData), .txReady(txReady),
		.firstTimerOutput(firstTimerOutput), .serialInPin(serialInPin),
		.serialOutPin(serialOutPin), .serialOutEnN(serialOutEnN),
		.serialClockIn(serialClockIn), .serialClockOut(serialClockOut),
		.serialClockEnN(serialClockEnN), .selectInN(selectInN),
		.spiInterruptLine(spiInterruptLine), .stopWakeSignal(stopWakeSignal));
	spi_far_end u_far (.clk(clk), .serialOutPin(serialOutPin), .serialOutEnN(serialOutEnN),
		.serialClockOut(serialClockOut), .serialInPin(serialInPin),
		.serialClockIn(serialClockIn), .selectInN(selectInN));
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w,
		output logic [7:0] q);
		@(posedge clk);
		#1 regAddr = a;
		regWdata = d;
		regWrite = w;
		regRead = !w;
		@(posedge clk);
		#1 regWrite = 1'b0;
		regRead = 1'b0;
		q = regRdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, d, 1'b1, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus(a, 8'h00, 1'b0, d);
	endtask : rd
	task automatic push(input logic [7:0] b);
		@(posedge clk);
		#1 txValid = 1'b1;
		txData = b;
		@(posedge clk);
		#1 txValid = 1'b0;
	endtask : push
	task automatic master_byte(input logic [7:0] c, input logic [7:0] t, input logic [7:0] r);
		int k;
		wr(`OFS_CONTROL, c);
		u_far.ph = c[`BIT_PHASE];
		u_far.slvTx = r;
		irqs = 0;
		push(t);
		for (k = 0; k < 400 && irqs == 0; k++) @(posedge clk);
		`CHK("master irq", 1, irqs)
		`CHK("master tx", t, u_far.slvRx)
		rd(`OFS_RECEIVE_HOLDING_BUFFER, rv); `CHK("master rx", r, rv)
	endtask : master_byte
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		#400000;
		fail_count++;
		stop_test();
	end
	initial begin
		int k;
		clk = 1'b0;
		resetn = 1'b0;
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 8'h00;
		txValid = 1'b0;
		txData = 8'h00;
		repeat (4) @(posedge clk);
		#1 resetn = 1'b1;
		rd(`OFS_CONTROL, rv); `CHK("control reset", 8'h00, rv)
		rd(8'h7E, rv); `CHK("unmapped read", 8'h00, rv)
		`CHK("out released", 1'b1, serialOutEnN)
		`CHK("fifo ready", 1'b1, txReady)
		// master run, slowest divisor so the model keeps up
		wr(`OFS_CONTROL, 8'h87);
		u_far.slvTx = 8'h3C;
		`CHK("clock driven", 1'b0, serialClockEnN)
		push(8'hA5);
		for (k = 0; k < 400 && irqs == 0; k++) @(posedge clk);
		`CHK("master irq", 1, irqs)
		`CHK("master tx", 8'hA5, u_far.slvRx)
		`CHK("select pin", 1'b1, selectInN)
		rd(`OFS_CONTROL, rv); `CHK("avail set", 8'h97, rv)
		rd(`OFS_RECEIVE_HOLDING_BUFFER, rv); `CHK("master rx", 8'h3C, rv)
		rd(`OFS_CONTROL, rv); `CHK("avail clear", 8'h87, rv)
		// faster divisor, timer source and the other clock phase
		master_byte(8'h83, 8'h96, 8'h69);
		master_byte(8'hC1, 8'h5C, 8'hC5);
		master_byte(8'hA5, 8'h3A, 8'hD2);
		// slave with compare: a matching header then a data byte
		wr(`OFS_MATCH, 8'h5A);
		wr(`OFS_CONTROL, 8'h09);
		irqs = 0;
		u_far.frame(1'b1);
		u_far.xfer(8'h5A, got);
		`CHK("no irq header", 0, irqs)
		`CHK("wake pulse", 1, wakes)
		u_far.xfer(8'h77, got);
		u_far.frame(1'b0);
		`CHK("data irq", 1, irqs)
		rd(`OFS_RECEIVE_HOLDING_BUFFER, rv); `CHK("slave rx", 8'h77, rv)
		// mismatching header: silent until deselect
		u_far.frame(1'b1);
		u_far.xfer(8'h11, got);
		`CHK("mismatch quiet", 1'b1, serialOutEnN)
		u_far.xfer(8'h22, got);
		u_far.frame(1'b0);
		`CHK("mismatch no irq", 1, irqs)
		`CHK("one wake only", 1, wakes)
		// plain slave: two unread bytes give overrun, then clear and release check
		wr(`OFS_CONTROL, 8'h01);
		push(8'hC3);
		u_far.frame(1'b1);
		u_far.xfer(8'h81, got);
		`CHK("slave tx", 8'hC3, got)
		u_far.xfer(8'h42, got);
		`CHK("idle tx", 8'hFF, got)
		u_far.frame(1'b0);
		`CHK("two irqs", 3, irqs)
		rd(`OFS_CONTROL, rv); `CHK("overrun set", 8'h13, rv)
		rd(`OFS_RECEIVE_HOLDING_BUFFER, rv); `CHK("overwritten", 8'h42, rv)
		rd(`OFS_CONTROL, rv); `CHK("overrun sticky", 8'h03, rv)
		wr(`OFS_CONTROL, 8'h05);
		rd(`OFS_CONTROL, rv); `CHK("overrun cleared", 8'h05, rv)
		`CHK("out released", 1'b1, serialOutEnN)
		// disabled: bytes raise no interrupt
		wr(`OFS_CONTROL, 8'h00);
		u_far.frame(1'b1);
		u_far.xfer(8'h99, got);
		u_far.frame(1'b0);
		`CHK("disabled no irq", 3, irqs)
		stop_test();
	end
endmodule : spi_with_address_compare_tb_top
`default_nettype wire

/* File: core/spi_with_address_compare.sv */
// serial peripheral interface with slave address compare and transmit fifo
// assumes all pins are synchronous to clk; select is active low
`timescale 1ns/100ps
`default_nettype none
`include "spi_regs.svh"

module tx_fifo #(
	parameter int WIDTH = `DATA_WIDTH,
	parameter int DEPTH = `TXFIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_ff;
	logic [AW-1:0]    rdPtr_ff;
	logic [AW:0]      count_ff;
	wire              doPush = inValid & inReady;
	wire              doPop  = outValid & outReady;

	assign inReady  = (count_ff != (AW+1)'(DEPTH));
	assign outValid = (count_ff != '0);
	assign outData  = mem[rdPtr_ff];

	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[wrPtr_ff] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			wrPtr_ff <= doPush ? wrPtr_ff + 1'b1 : wrPtr_ff;
			rdPtr_ff <= doPop ? rdPtr_ff + 1'b1 : rdPtr_ff;
			count_ff <= count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end
endmodule : tx_fifo

// Operation
// - bit 0 enables interface; starts disabled
// - master: bits 2:1 pick clock divisor
// - slave: bit 1 sticky overrun, software clears
// - slave: bit 2 releases data out pin
// - bit 3 enables compare against match value
// - bit 4 shows byte waiting, raises interrupt
// - bit 5 picks sample and drive edges
// - bit 6 picks timer output or divided clock
// - bit 7 selects master or slave
// - slave transfer framed by select from master
// - eight bits set available, interrupt, continue
// - unread buffer: set overrun, overwrite byte
// - slave drives one bit per received bit
// - slave clock is input; master drives it
// - master never drives slave select itself
// - master: loading shift register starts transfer
// - master byte end sets available and interrupt
// - compare byte: no transmit, no interrupt
// - mismatch: silent until select released
// - match: wake pulse, then normal transfer
// - disabled interface gives interrupt no source
// - slave keeps working in all sleep modes
// - reading buffer clears available flag
module spi_with_address_compare
	import spi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	input  wire logic       txValid,
	input  wire logic [7:0] txData,
	output logic            txReady,
	input  wire logic       firstTimerOutput,
	input  wire logic       serialInPin,
	output logic            serialOutPin,
	output logic            serialOutEnN,
	input  wire logic       serialClockIn,
	output logic            serialClockOut,
	output logic            serialClockEnN,
	input  wire logic       selectInN,
	output logic            spiInterruptLine,
	output logic            stopWakeSignal
);
	ctrl_type       ctrl_ff;
	link_state_type state_ff;
	link_state_type nxt_state;
	logic [7:0]     matchValue_ff;
	logic [7:0]     holding_ff;
	logic [7:0]     rxShift_ff;
	logic [7:0]     txShift_ff;
	logic [3:0]     bitCnt_ff;
	logic [4:0]     togCnt_ff;
	logic [3:0]     divCnt_ff;
	logic           sckPrev_ff;
	logic           tmrPrev_ff;
	logic [7:0]     rdData_ff;
	logic           irq_ff;
	logic           wake_ff;
	logic           fifoValid;
	logic [7:0]     fifoData;

	// register decode
	wire hitCtrl   = (regAddr == `OFS_CONTROL);
	wire hitMatch  = (regAddr == `OFS_MATCH);
	wire hitRxbuf  = (regAddr == `OFS_RECEIVE_HOLDING_BUFFER);
	wire wrCtrl    = regWrite & hitCtrl;
	wire rdClear   = regRead & hitRxbuf;
	wire isMaster  = ctrl_ff.master;
	wire selected  = ~selectInN;

	// clock tick generation
	wire [3:0] halfLimit = 4'h1 << {ctrl_ff.divHi, ctrl_ff.divLo};
	wire divTick   = (divCnt_ff == halfLimit - 4'h1);
	wire tmrTick   = firstTimerOutput ^ tmrPrev_ff;
	wire halfTick  = ctrl_ff.clkSrc ? tmrTick : divTick;

	// edges of the serial clock, own or external
	wire busy      = (state_ff != LINK_IDLE);
	wire mstRise   = isMaster & busy & halfTick & ~serialClockOut;
	wire mstFall   = isMaster & busy & halfTick & serialClockOut;
	wire slvRise   = ~isMaster & selected & serialClockIn & ~sckPrev_ff;
	wire slvFall   = ~isMaster & selected & ~serialClockIn & sckPrev_ff;
	wire sckRise   = mstRise | slvRise;
	wire sckFall   = mstFall | slvFall;
	wire sampleNow = ctrl_ff.phase ? sckFall : sckRise;
	wire driveNow  = ctrl_ff.phase ? sckRise : sckFall;

	wire shifting  = (state_ff == LINK_XFER) | (state_ff == LINK_COMPARE);
	wire doSample  = shifting & sampleNow;
	wire doDrive   = shifting & driveNow & (bitCnt_ff != 4'h0);
	wire byteDone  = doSample & (bitCnt_ff == `BITS_PER_BYTE - 4'h1);
	wire [7:0] rxByte = {rxShift_ff[6:0], serialInPin};
	wire inCompare = (state_ff == LINK_COMPARE);
	wire matchHit  = byteDone & inCompare & (rxByte == matchValue_ff);
	wire dataDone  = byteDone & (state_ff == LINK_XFER);
	wire mstLast   = mstFall & (togCnt_ff == `TOGGLES_BYTE - 5'h1);

	// starting a transfer
	wire mstStart  = ctrl_ff.enable & isMaster & ~busy & fifoValid;
	wire slvStart  = ctrl_ff.enable & ~isMaster & ~busy & selected;
	wire slvLoad   = (slvStart & ~ctrl_ff.compareEn) | matchHit
		| (dataDone & ~isMaster);
	wire loadReq   = mstStart | slvLoad;
	wire fifoPop   = loadReq & fifoValid;
	wire [7:0] loadByte = fifoValid ? fifoData : `IDLE_TXBYTE;

	// software write of bit 1 to zero clears overrun; a new overrun wins
	wire overrunSet = dataDone & ~isMaster & ctrl_ff.availFlag & ~rdClear;
	wire bit1Write  = wrCtrl ? regWdata[`BIT_OVERRUN] : ctrl_ff.divLo;
	wire nxtBit1    = bit1Write | overrunSet;
	wire nxtAvail   = dataDone | (ctrl_ff.availFlag & ~rdClear);

	tx_fifo #(
		.WIDTH (`DATA_WIDTH),
		.DEPTH (`TXFIFO_DEPTH)
	) u_txFifo (
		.clk      (clk),
		.resetn   (resetn),
		.inValid  (txValid),
		.inData   (txData),
		.inReady  (txReady),
		.outValid (fifoValid),
		.outData  (fifoData),
		.outReady (loadReq)
	);

	// link state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			LINK_IDLE: begin
				if (mstStart) begin
					nxt_state = LINK_XFER;
				end else if (slvStart) begin
					nxt_state = ctrl_ff.compareEn ? LINK_COMPARE : LINK_XFER;
				end
			end
			LINK_COMPARE: begin
				if (byteDone) begin
					nxt_state = matchHit ? LINK_XFER : LINK_IGNORE;
				end
			end
			LINK_IGNORE: begin
				nxt_state = LINK_IGNORE;
			end
			LINK_XFER: begin
				if (mstLast) begin
					nxt_state = LINK_IDLE;
				end
			end
			default: begin
				nxt_state = LINK_IDLE;
			end
		endcase
		// deselect ends any slave exchange; disabling ends everything
		if (!ctrl_ff.enable || (!isMaster && !selected)) begin
			nxt_state = LINK_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff <= LINK_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// control, match and holding registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_ff       <= `RST_CONTROL;
			matchValue_ff <= `RST_MATCH;
			holding_ff    <= `RST_RECEIVE_HOLDING_BUFFER;
		end else begin
			if (wrCtrl) begin
				ctrl_ff.master    <= regWdata[`BIT_MASTER];
				ctrl_ff.clkSrc    <= regWdata[`BIT_CLKSRC];
				ctrl_ff.phase     <= regWdata[`BIT_PHASE];
				ctrl_ff.compareEn <= regWdata[`BIT_COMPARE];
				ctrl_ff.divHi     <= regWdata[`BIT_DIV_HI];
				ctrl_ff.enable    <= regWdata[`BIT_ENABLE];
			end
			ctrl_ff.divLo     <= nxtBit1;
			ctrl_ff.availFlag <= nxtAvail;
			if (regWrite && hitMatch) begin
				matchValue_ff <= regWdata;
			end
			if (dataDone) begin
				holding_ff <= rxByte;
			end
		end
	end

	// shift engine
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxShift_ff <= 8'h00;
			txShift_ff <= `IDLE_TXBYTE;
			bitCnt_ff  <= 4'h0;
		end else begin
			if (doSample) begin
				rxShift_ff <= rxByte;
			end
			if (loadReq) begin
				txShift_ff <= loadByte;
			end else if (doDrive) begin
				txShift_ff <= {txShift_ff[6:0], 1'b1};
			end
			if (!busy || byteDone) begin
				bitCnt_ff <= 4'h0;
			end else if (doSample) begin
				bitCnt_ff <= bitCnt_ff + 4'h1;
			end
		end
	end

	// master serial clock; idle low, toggles only while a byte runs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			serialClockOut <= 1'b0;
			togCnt_ff      <= 5'h00;
			divCnt_ff      <= 4'h0;
			sckPrev_ff     <= 1'b0;
			tmrPrev_ff     <= 1'b0;
		end else begin
			sckPrev_ff <= serialClockIn;
			tmrPrev_ff <= firstTimerOutput;
			divCnt_ff  <= (divTick || !busy) ? 4'h0 : divCnt_ff + 4'h1;
			if (!busy || !isMaster) begin
				serialClockOut <= 1'b0;
				togCnt_ff      <= 5'h00;
			end else if (halfTick) begin
				serialClockOut <= ~serialClockOut;
				togCnt_ff      <= togCnt_ff + 5'h01;
			end
		end
	end

	// events and read data; interrupt fires only while enabled
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_ff    <= 1'b0;
			wake_ff   <= 1'b0;
			rdData_ff <= 8'h00;
		end else begin
			irq_ff  <= dataDone & ctrl_ff.enable;
			wake_ff <= matchHit;
			if (regRead) begin
				rdData_ff <= hitCtrl ? ctrl_ff : (hitMatch ? matchValue_ff
					: (hitRxbuf ? holding_ff : 8'h00));
			end
		end
	end

	// the slave select is left to a general port line in master mode
	wire slvDrive = ~isMaster & (state_ff == LINK_XFER) & ~ctrl_ff.divHi;
	wire mstDrive = isMaster & busy;

	assign regRdata         = rdData_ff;
	assign spiInterruptLine = irq_ff;
	assign stopWakeSignal   = wake_ff;
	assign serialOutPin     = txShift_ff[7];
	assign serialOutEnN     = ~(ctrl_ff.enable & (mstDrive | slvDrive));
	assign serialClockEnN   = ~(ctrl_ff.enable & isMaster);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [3:0] gapCnt_ff;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gapCnt_ff <= 4'h0;
		end else begin
			// held at zero while idle so the first half period counts from the start
			gapCnt_ff <= !busy ? 4'h0 : ((serialClockOut != $past(serialClockOut)) ? 4'h1
				: gapCnt_ff + 4'h1);
		end
	end

	chk_disabled_quiet: assert property (
		!ctrl_ff.enable |-> serialOutEnN && !spiInterruptLine)
		else $error("output driven while disabled");
	chk_master_half_rate: assert property (
		isMaster && busy && !ctrl_ff.clkSrc && $changed(serialClockOut)
		&& $past(busy, 2) && $past(serialClockOut) == $past(serialClockOut, 2)
		|-> gapCnt_ff == halfLimit)
		else $error("master clock half period wrong");
	chk_overrun_sticky: assert property (
		!isMaster && ctrl_ff.divLo && !wrCtrl |=> ctrl_ff.divLo)
		else $error("overrun flag lost");
	chk_release_out: assert property (
		!isMaster && ctrl_ff.divHi |-> serialOutEnN)
		else $error("released pin still driven");
	chk_byte_avail: assert property (
		dataDone && ctrl_ff.enable |=> ctrl_ff.availFlag && spiInterruptLine)
		else $error("byte end without flag and interrupt");
	chk_overrun_set: assert property (
		overrunSet |=> ctrl_ff.divLo && holding_ff == $past(rxByte))
		else $error("overrun not logged");
	chk_slave_clock_in: assert property (
		!isMaster |-> serialClockEnN)
		else $error("slave drives clock");
	chk_compare_silent: assert property (
		inCompare |-> serialOutEnN ##1 !spiInterruptLine)
		else $error("compare byte transmitted or interrupted");
	chk_mismatch_ignore: assert property (
		state_ff == LINK_IGNORE |-> serialOutEnN && !dataDone)
		else $error("ignored slave active");
	chk_match_wake: assert property (
		matchHit |=> stopWakeSignal && state_ff == LINK_XFER)
		else $error("match without wake");
	chk_read_clears: assert property (
		rdClear && !dataDone |=> !ctrl_ff.availFlag)
		else $error("read left flag set");

	cov_master_byte: cover property (mstLast);
	cov_slave_match: cover property (matchHit);
	cov_slave_overrun: cover property (overrunSet);
	cov_timer_byte: cover property (mstLast && ctrl_ff.clkSrc);
endmodule : spi_with_address_compare
`default_nettype wire

/* File: shared/spi_pkg.sv */
// types shared by the serial interface
// uses no values from spi_regs.svh; field order sets bit positions
`default_nettype none
package spi_pkg;

	typedef struct packed {
		logic master;
		logic clkSrc;
		logic phase;
		logic availFlag;
		logic compareEn;
		logic divHi;
		logic divLo;
		logic enable;
	} ctrl_type;

	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_COMPARE,
		LINK_IGNORE,
		LINK_XFER
	} link_state_type;

endpackage : spi_pkg
`default_nettype wire

/* File: shared/spi_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit register port on the timer clock of the device
`ifndef SPI_REGS_SVH
`define SPI_REGS_SVH

`define OFS_RECEIVE_HOLDING_BUFFER      8'h00
`define OFS_MATCH      8'h01
`define OFS_CONTROL    8'h02

`define BIT_ENABLE     0
`define BIT_DIV_LO     1
`define BIT_OVERRUN    1
`define BIT_DIV_HI     2
`define BIT_RELEASE    2
`define BIT_COMPARE    3
`define BIT_AVAIL      4
`define BIT_PHASE      5
`define BIT_CLKSRC     6
`define BIT_MASTER     7

`define RST_CONTROL    8'h00
`define RST_MATCH      8'h00
`define RST_RECEIVE_HOLDING_BUFFER      8'h00
`define IDLE_TXBYTE    8'hFF

`define BITS_PER_BYTE  4'h8
`define TOGGLES_BYTE   5'h10
`define TXFIFO_DEPTH   32
`define DATA_WIDTH     8

`endif
